/* File: logic/drive_param_bank.v */
// Monitor and diagnosis parameter bank of a servo drive
//
// Functional notes
// - Current alarm in 16-bit register, zero if none
// - Alarm code held as BCD digits
// - Codes 001-009 for power-stage faults
// - Undervoltage only while enabled, self-clearing
// - Encoder fault codes 011, 018, 024-027
// - Codes 012, 014-017 for adjust, limits, temperature
// - Codes 020, 022, 023 for comm, phase, pre-overload
// - Codes 030, 031, 040, 099 for motor, firmware
// - Motion codes 283, 285, 380
// - Five-entry alarm history, newest first, reset zero
// - Selector 00-05 shows position counts
// - Selector 06-17 shows speed, load, voltage quantities
// - Selector 18 shows index-relative position within 5000
// - Selector 19-22 shows mapping parameters
// - Selector 23-26 shows status monitors
// - Analog monitor selector accepts 0x0000 to 0x0077, each nibble 0-7
// - Slave address default 127, written value stored but never applied
// - Response delay in 0.5 ms steps, default zero
// - Servo-on locked parameters refuse writes while enabled
// - Restart parameters stored and read back, never applied to outputs
// - Undervoltage threshold default 160 V compared
// - Analog selector nibbles pick channel quantities
`timescale 1ns/1ns
module drive_param_bank
(
    input wire core_clk,
    input wire sys_rst,
    input wire [15:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    output reg [15:0] regRdData,
    output reg regRdValid,
    output reg regWrRefused,
    input wire servoOnPin,
    input wire [30:0] faultVec,
    input wire [15:0] mainVoltage,
    input wire [511:0] statusValues,
    output reg [15:0] firmwareRevision,
    output reg [7:0] slaveAddress,
    output reg [2:0] analogCh1Sel,
    output reg [2:0] analogCh2Sel,
    output reg undervoltageDetect,
    output reg [31:0] driveStatusValue,
    output reg responseReady
);
`include "drive_param_regs.vh"

    // Arbitrary revision value, not tied to any real product
    parameter [15:0] FW_REVISION = 16'h0100;
    localparam [15:0] SLAVE_RST = `RST_SLAVE_ADDR;

    // Status vector holds 16 words of 32 bits: quantities 0..17 folded into slots
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WAIT = 4'b0010;
    localparam [3:0] ST_ANSWER = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;

    reg [2:0] servoSync;
    reg servoOn_q;
    reg [15:0] statusSel_q;
    reg [15:0] analogSel_q;
    reg [15:0] slaveAddrStored_q;
    reg [15:0] respDelay_q;
    reg [15:0] uvThresh_q;
    reg [31:0] history_q [0:4];
    reg [15:0] lastAlarm_q;
    reg [3:0] state_q;
    reg [31:0] stepCnt_q;
    reg [15:0] stepsLeft_q;
    reg [15:0] pendData_q;
    reg [15:0] answerData;
    reg [31:0] histWord;
    reg [31:0] selValue;
    reg signed [31:0] indexPos;
    wire [15:0] alarmCode;
    wire [30:0] faultMasked;
    wire wordHigh;
    wire [15:0] wordBase;
    integer i;

    // Word pairs: bit 0 picks the high half of a 32-bit parameter
    assign wordHigh = regAddr[0];
    assign wordBase = {regAddr[15:1], 1'b0};

    // Undervoltage source comes from the threshold compare, not the input vector
    assign faultMasked = {faultVec[30:3], undervoltageDetect, faultVec[1:0]};

    alarm_code_encoder alarmEnc
    (
        .faultVec(faultMasked),
        .servoOn(servoOn_q),
        .alarmCode(alarmCode)
    );

    // Servo-on pin crosses from outside; accept once stages two and three agree
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            servoSync <= 3'b000;
            servoOn_q <= 1'b0;
        end
        else
        begin
            servoSync <= {servoSync[1:0], servoOnPin};
            if (servoSync[1] == servoSync[2])
                servoOn_q <= servoSync[2];
        end
    end

    // Range check for the analog selector: both nibbles must be 0..7
    function analogSelValid;
        input [15:0] v;
        begin
            analogSelValid = (v <= `ANALOG_SEL_MAX) && (v[3] == 1'b0);
        end
    endfunction

    // Locked parameters: analog selector is a servo-on locked parameter
    function isServoLocked;
        input [15:0] a;
        begin
            isServoLocked = (a == `ADDR_ANALOG_SEL);
        end
    endfunction

    // Clamp the index-relative position into its documented window
    function signed [31:0] clampIndex;
        input signed [31:0] v;
        begin
            if (v > `INDEX_POS_MAX)
                clampIndex = `INDEX_POS_MAX;
            else if (v < -`INDEX_POS_MAX)
                clampIndex = -`INDEX_POS_MAX;
            else
                clampIndex = v;
        end
    endfunction

    // Writable parameters; read-only addresses simply do not match
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            statusSel_q <= `RST_STATUS_SEL;
            analogSel_q <= `RST_ANALOG_SEL;
            slaveAddrStored_q <= `RST_SLAVE_ADDR;
            respDelay_q <= `RST_RESP_DELAY;
            uvThresh_q <= `RST_UV_THRESH;
            regWrRefused <= 1'b0;
        end
        else
        begin
            regWrRefused <= 1'b0;
            if (regWrEn && !wordHigh)
            begin
                if (isServoLocked(wordBase) && servoOn_q)
                    regWrRefused <= 1'b1;
                else
                begin
                    case (wordBase)
                        `ADDR_STATUS_SEL:
                        begin
                            if (regWrData <= `STATUS_SEL_MAX)
                                statusSel_q <= regWrData;
                            else
                                regWrRefused <= 1'b1;
                        end
                        `ADDR_ANALOG_SEL:
                        begin
                            if (analogSelValid(regWrData))
                                analogSel_q <= regWrData;
                            else
                                regWrRefused <= 1'b1;
                        end
                        `ADDR_SLAVE_ADDR: slaveAddrStored_q <= regWrData;
                        `ADDR_RESP_DELAY: respDelay_q <= regWrData;
                        `ADDR_UV_THRESH: uvThresh_q <= regWrData;
                        default: regWrRefused <= 1'b1;
                    endcase
                end
            end
            else if (regWrEn)
                regWrRefused <= 1'b1;
        end
    end

    // Restart-class slave address applies only on reset, from the default
    always @(posedge core_clk)
    begin
        if (sys_rst)
            slaveAddress <= SLAVE_RST[7:0];
        else
            slaveAddress <= slaveAddress;
    end

    // Fixed outputs and decoded analog channels
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            firmwareRevision <= 16'h0000;
            analogCh1Sel <= 3'b000;
            analogCh2Sel <= 3'b000;
            undervoltageDetect <= 1'b0;
        end
        else
        begin
            firmwareRevision <= FW_REVISION;
            analogCh1Sel <= analogSel_q[6:4];
            analogCh2Sel <= analogSel_q[2:0];
            // Level compare clears by itself once voltage recovers
            undervoltageDetect <= (mainVoltage < uvThresh_q);
        end
    end

    // History shifts on each new non-zero alarm; newest at index 0
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            for (i = 0; i < 5; i = i + 1)
                history_q[i] <= 32'h0000_0000;
            lastAlarm_q <= `ALM_NONE;
        end
        else
        begin
            lastAlarm_q <= alarmCode;
            if (alarmCode != `ALM_NONE && alarmCode != lastAlarm_q)
            begin
                for (i = 4; i > 0; i = i - 1)
                    history_q[i] <= history_q[i - 1];
                history_q[0] <= {16'h0000, alarmCode};
            end
        end
    end

    // Selector mux: codes 0..26 choose a 32-bit slot of the status input
    always @*
    begin
        selValue = 32'h0000_0000;
        indexPos = 32'sd0;
        if (statusSel_q <= 16'h0011)
            selValue = statusValues[statusSel_q[4:0] % 16 * 32 +: 32];
        else if (statusSel_q == 16'h0012)
        begin
            indexPos = clampIndex(statusValues[479:448]);
            selValue = indexPos;
        end
        else if (statusSel_q <= 16'h0016)
            selValue = statusValues[(statusSel_q[2:0] + 3'd1) % 8 * 32 + 256 +: 32];
        else if (statusSel_q <= `STATUS_SEL_MAX)
            selValue = statusValues[(statusSel_q[2:0] + 3'd1) % 4 * 32 +: 32];
    end

    always @(posedge core_clk)
    begin
        if (sys_rst)
            driveStatusValue <= 32'h0000_0000;
        else
            driveStatusValue <= selValue;
    end

    // Read decode over word pairs, low half at the even address
    always @*
    begin
        histWord = 32'h0000_0000;
        answerData = 16'h0000;
        case (wordBase)
            `ADDR_HIST_NEWEST: histWord = history_q[0];
            `ADDR_HIST_SECOND: histWord = history_q[1];
            `ADDR_HIST_THIRD: histWord = history_q[2];
            `ADDR_HIST_FOURTH: histWord = history_q[3];
            `ADDR_HIST_OLDEST: histWord = history_q[4];
            default: histWord = 32'h0000_0000;
        endcase
        case (wordBase)
            `ADDR_FW_REV: answerData = wordHigh ? 16'h0000 : FW_REVISION;
            `ADDR_ALARM_CODE: answerData = wordHigh ? 16'h0000 : alarmCode;
            `ADDR_STATUS_SEL: answerData = wordHigh ? 16'h0000 : statusSel_q;
            `ADDR_ANALOG_SEL: answerData = wordHigh ? 16'h0000 : analogSel_q;
            `ADDR_SLAVE_ADDR: answerData = wordHigh ? 16'h0000 : slaveAddrStored_q;
            `ADDR_RESP_DELAY: answerData = wordHigh ? 16'h0000 : respDelay_q;
            `ADDR_UV_THRESH: answerData = wordHigh ? 16'h0000 : uvThresh_q;
            default: answerData = wordHigh ? histWord[31:16] : histWord[15:0];
        endcase
    end

    // Reply sequencer: hold the answer for the programmed delay
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            stepCnt_q <= 32'd0;
            stepsLeft_q <= 16'h0000;
            pendData_q <= 16'h0000;
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
            responseReady <= 1'b0;
        end
        else
        begin
            regRdValid <= 1'b0;
            responseReady <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (regRdEn)
                    begin
                        pendData_q <= answerData;
                        stepsLeft_q <= respDelay_q;
                        stepCnt_q <= 32'd0;
                        state_q <= (respDelay_q == 16'h0000) ? ST_ANSWER : ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    // Each step is a full 0.5 ms of clock cycles
                    if (stepCnt_q == `RESP_STEP_CYCLES - 1)
                    begin
                        stepCnt_q <= 32'd0;
                        stepsLeft_q <= stepsLeft_q - 16'h0001;
                        if (stepsLeft_q == 16'h0001)
                            state_q <= ST_ANSWER;
                    end
                    else
                        stepCnt_q <= stepCnt_q + 32'd1;
                end
                ST_ANSWER:
                begin
                    regRdData <= pendData_q;
                    regRdValid <= 1'b1;
                    responseReady <= 1'b1;
                    state_q <= ST_DONE;
                end
                ST_DONE:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // drive_param_bank

/* File: logic/drive_param_regs.vh */
// Register offsets, reset values, limits, alarm codes and timing counts of the drive parameter bank
`ifndef DRIVE_PARAM_REGS_VH
`define DRIVE_PARAM_REGS_VH
// Word addresses: each parameter takes a low word and a high word
`define ADDR_FW_REV 16'h0000
`define ADDR_ALARM_CODE 16'h0002
`define ADDR_STATUS_SEL 16'h0004
`define ADDR_ANALOG_SEL 16'h0006
`define ADDR_SLAVE_ADDR 16'h0100
`define ADDR_RESP_DELAY 16'h0102
`define ADDR_HIST_NEWEST 16'h0200
`define ADDR_HIST_SECOND 16'h0202
`define ADDR_HIST_THIRD 16'h0204
`define ADDR_HIST_FOURTH 16'h0206
`define ADDR_HIST_OLDEST 16'h0208
`define ADDR_UV_THRESH 16'h0230
// Reset values
`define RST_STATUS_SEL 16'h0001
`define RST_ANALOG_SEL 16'h0000
`define RST_SLAVE_ADDR 16'h007F
`define RST_RESP_DELAY 16'h0000
`define RST_UV_THRESH 16'h00A0
// Limits
`define ANALOG_SEL_MAX 16'h0077
`define STATUS_SEL_MAX 16'h001A
// Alarm codes, stored as BCD digits
`define ALM_NONE 16'h0000
`define ALM_OVERCURRENT 16'h0001
`define ALM_OVERVOLTAGE 16'h0002
`define ALM_UNDERVOLTAGE 16'h0003
`define ALM_MOTOR_MISMATCH 16'h0004
`define ALM_BRAKE_RES 16'h0005
`define ALM_OVERLOAD 16'h0006
`define ALM_OVERSPEED 16'h0007
`define ALM_PULSE_CMD 16'h0008
`define ALM_DEVIATION 16'h0009
`define ALM_ENC_WIRING 16'h0011
`define ALM_ADJUST 16'h0012
`define ALM_REV_LIMIT 16'h0014
`define ALM_FWD_LIMIT 16'h0015
`define ALM_IGBT_TEMP 16'h0016
`define ALM_MEMORY 16'h0017
`define ALM_ENC_OUTPUT 16'h0018
`define ALM_COMM_TIMEOUT 16'h0020
`define ALM_PHASE_LOSS 16'h0022
`define ALM_PRE_OVERLOAD 16'h0023
`define ALM_ENC_FIELD 16'h0024
`define ALM_ENC_INTERNAL 16'h0025
`define ALM_ENC_DATA 16'h0026
`define ALM_ENC_RESET 16'h0027
`define ALM_MOTOR_WATCH 16'h0030
`define ALM_UVW_WIRING 16'h0031
`define ALM_FULL_LOOP_DEV 16'h0040
`define ALM_FW_UPGRADE 16'h0099
`define ALM_FWD_SW_LIMIT 16'h0283
`define ALM_REV_SW_LIMIT 16'h0285
`define ALM_POS_DEV 16'h0380
// Width of the fault vector, one bit per alarm source; bit 9 is unused
`define FAULT_COUNT 31
// Response delay step: 0.5 ms at 10 ns clock
`define RESP_STEP_US10 5
`define CLK_PERIOD_NS 10
`define RESP_STEP_CYCLES ((`RESP_STEP_US10 * 100000) / `CLK_PERIOD_NS)
// Encoder index window and encoder resolution
`define INDEX_POS_MAX 32'sd5000
`define ENC_PULSES_PER_REV 32'd1280000
`endif

/* File: logic/alarm_code_encoder.v */
// Priority encoder from the fault vector to a BCD alarm code
`timescale 1ns/1ns
module alarm_code_encoder
(
    input wire [30:0] faultVec,
    input wire servoOn,
    output reg [15:0] alarmCode
);
`include "drive_param_regs.vh"

    // Lowest bit wins; undervoltage is masked while the drive is disabled
    always @*
    begin
        alarmCode = `ALM_NONE;
        if (faultVec[30]) alarmCode = `ALM_POS_DEV;
        if (faultVec[29]) alarmCode = `ALM_REV_SW_LIMIT;
        if (faultVec[28]) alarmCode = `ALM_FWD_SW_LIMIT;
        if (faultVec[27]) alarmCode = `ALM_FW_UPGRADE;
        if (faultVec[26]) alarmCode = `ALM_FULL_LOOP_DEV;
        if (faultVec[25]) alarmCode = `ALM_UVW_WIRING;
        if (faultVec[24]) alarmCode = `ALM_MOTOR_WATCH;
        if (faultVec[23]) alarmCode = `ALM_ENC_RESET;
        if (faultVec[22]) alarmCode = `ALM_ENC_DATA;
        if (faultVec[21]) alarmCode = `ALM_ENC_INTERNAL;
        if (faultVec[20]) alarmCode = `ALM_ENC_FIELD;
        if (faultVec[19]) alarmCode = `ALM_PRE_OVERLOAD;
        if (faultVec[18]) alarmCode = `ALM_PHASE_LOSS;
        if (faultVec[17]) alarmCode = `ALM_COMM_TIMEOUT;
        if (faultVec[16]) alarmCode = `ALM_ENC_OUTPUT;
        if (faultVec[15]) alarmCode = `ALM_MEMORY;
        if (faultVec[14]) alarmCode = `ALM_IGBT_TEMP;
        if (faultVec[13]) alarmCode = `ALM_FWD_LIMIT;
        if (faultVec[12]) alarmCode = `ALM_REV_LIMIT;
        if (faultVec[11]) alarmCode = `ALM_ADJUST;
        if (faultVec[10]) alarmCode = `ALM_ENC_WIRING;
        if (faultVec[8]) alarmCode = `ALM_DEVIATION;
        if (faultVec[7]) alarmCode = `ALM_PULSE_CMD;
        if (faultVec[6]) alarmCode = `ALM_OVERSPEED;
        if (faultVec[5]) alarmCode = `ALM_OVERLOAD;
        if (faultVec[4]) alarmCode = `ALM_BRAKE_RES;
        if (faultVec[3]) alarmCode = `ALM_MOTOR_MISMATCH;
        if (faultVec[2] && servoOn) alarmCode = `ALM_UNDERVOLTAGE;
        if (faultVec[1]) alarmCode = `ALM_OVERVOLTAGE;
        if (faultVec[0]) alarmCode = `ALM_OVERCURRENT;
    end

endmodule // alarm_code_encoder

/* File: testbench/drive_param_bank_sva.sv */
// Port assertions for the drive parameter bank
`timescale 1ns/1ns
`include "drive_param_regs.vh"
module drive_param_bank_sva
#(
    parameter [15:0] FW_REVISION = 16'h0100
)
(
    input wire core_clk,
    input wire sys_rst,
    input wire [15:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWrEn,
    input wire regRdValid,
    input wire regWrRefused,
    input wire responseReady,
    input wire [15:0] firmwareRevision,
    input wire [7:0] slaveAddress
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Write aimed at a place that never takes data
    sequence s_ro_write;
        regWrEn && (regAddr == `ADDR_FW_REV || regAddr == `ADDR_ALARM_CODE
            || (regAddr >= `ADDR_HIST_SECOND && regAddr <= 16'h0209));
    endsequence
    // One-cycle answer pulse
    sequence s_answer;
        regRdValid ##1 !regRdValid;
    endsequence
    property p_ro_refused; s_ro_write |=> regWrRefused; endproperty
    a_ro_refused: assert property (p_ro_refused)
        else $error("read-only write not refused");
    property p_valid_pulse; regRdValid |-> s_answer; endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("answer pulse longer than one cycle");
    property p_ready_same; responseReady == regRdValid; endproperty
    a_ready_same: assert property (p_ready_same)
        else $error("response ready differs from answer pulse");
    property p_odd_refused; regWrEn && regAddr[0] |=> regWrRefused; endproperty
    a_odd_refused: assert property (p_odd_refused)
        else $error("write to high word not refused");
    property p_analog_range;
        regWrEn && regAddr == `ADDR_ANALOG_SEL && regWrData > `ANALOG_SEL_MAX |=> regWrRefused;
    endproperty
    a_analog_range: assert property (p_analog_range)
        else $error("monitor select out of range accepted");
    property p_sel_range;
        regWrEn && regAddr == `ADDR_STATUS_SEL && regWrData > `STATUS_SEL_MAX |=> regWrRefused;
    endproperty
    a_sel_range: assert property (p_sel_range)
        else $error("status select out of range accepted");
    property p_refuse_cause; regWrRefused |-> $past(regWrEn); endproperty
    a_refuse_cause: assert property (p_refuse_cause)
        else $error("refusal without a write");
    // Slave address output only moves through reset, never from a write
    property p_slave_hold; !$past(sys_rst) |-> $stable(slaveAddress); endproperty
    a_slave_hold: assert property (p_slave_hold)
        else $error("slave address changed without restart");
    property p_fw_value; !$past(sys_rst) |-> firmwareRevision == FW_REVISION; endproperty
    a_fw_value: assert property (p_fw_value)
        else $error("revision output wrong");
endmodule // drive_param_bank_sva

bind drive_param_bank drive_param_bank_sva #(.FW_REVISION(FW_REVISION)) u_drive_param_bank_sva
(
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdValid(regRdValid),
    .regWrRefused(regWrRefused),
    .responseReady(responseReady),
    .firmwareRevision(firmwareRevision),
    .slaveAddress(slaveAddress)
);

/* File: testbench/modbus_master_model.sv */
// Register master model standing in for the serial master or keypad
`timescale 1ns/1ns
module modbus_master_model
(
    input wire core_clk,
    input wire regRdValid,
    input wire regWrRefused,
    input wire [15:0] regRdData,
    output logic [15:0] regAddr,
    output logic [15:0] regWrData,
    output logic regWrEn,
    output logic regRdEn
);
    // Idle bus with strobes low
    initial
    begin
        regAddr = 16'hFFFE;
        regWrData = 16'h0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    // One-cycle write strobe; refusal is sampled in the following cycle
    task automatic wr(input logic [15:0] a, input logic [15:0] d, output logic refused);
        @(posedge core_clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge core_clk);
        #1;
        regWrEn = 1'b0;
        refused = regWrRefused;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    // Address held until the answer pulse; bounded so a stall cannot hang
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 16'h0000;
        @(posedge core_clk);
        #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge core_clk);
        #1;
        regRdEn = 1'b0;
        for (n = 0; n < 60000 && !ok; n++)
        begin
            @(posedge core_clk);
            #1;
            if (regRdValid === 1'b1)
            begin
                ok = 1'b1;
                d = regRdData;
            end
        end
        regAddr = ~a;
    endtask
endmodule // modbus_master_model

/* File: testbench/drive_param_bank_tb_top.sv */
// Self-checking testbench of the drive parameter bank
`timescale 1ns/1ns
`include "drive_param_regs.vh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module drive_param_bank_tb_top;
    localparam logic [15:0] FW_VALUE = 16'h2A5C; // Arbitrary revision value
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic servoOnPin = 1'b0;
    logic [30:0] faultVec = 31'h0000_0000;
    logic [15:0] mainVoltage = 16'd220;
    logic [511:0] statusValues;
    wire [15:0] regAddr, regWrData, regRdData, firmwareRevision;
    wire regWrEn, regRdEn, regRdValid, regWrRefused, undervoltageDetect, responseReady;
    wire [7:0] slaveAddress;
    wire [2:0] analogCh1Sel, analogCh2Sel;
    wire [31:0] driveStatusValue;
    int errors = 0;
    int check_count = 0;
    // Expected alarm per fault bit; bit 2 is replaced by the threshold compare, bit 9 is unused
    logic [15:0] codes [0:30] = '{16'h0001, 16'h0002, 16'h0000, 16'h0004, 16'h0005,
        16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h0000, 16'h0011, 16'h0012, 16'h0014,
        16'h0015, 16'h0016, 16'h0017, 16'h0018, 16'h0020, 16'h0022, 16'h0023, 16'h0024,
        16'h0025, 16'h0026, 16'h0027, 16'h0030, 16'h0031, 16'h0040, 16'h0099, 16'h0283,
        16'h0285, 16'h0380};

    always #5 core_clk = ~core_clk;

    drive_param_bank #(.FW_REVISION(FW_VALUE)) u_drive_param_bank
    (
        .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .regWrRefused(regWrRefused), .servoOnPin(servoOnPin), .faultVec(faultVec),
        .mainVoltage(mainVoltage), .statusValues(statusValues),
        .firmwareRevision(firmwareRevision), .slaveAddress(slaveAddress),
        .analogCh1Sel(analogCh1Sel), .analogCh2Sel(analogCh2Sel),
        .undervoltageDetect(undervoltageDetect), .driveStatusValue(driveStatusValue),
        .responseReady(responseReady)
    );

    modbus_master_model u_modbus_master_model
    (
        .core_clk(core_clk), .regRdValid(regRdValid), .regWrRefused(regWrRefused),
        .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn)
    );

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Read and compare; a lost answer ends the run
    task automatic rdx(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic ok;
        u_modbus_master_model.rd(a, d, ok);
        if (ok !== 1'b1)
        begin
            errors++;
            $display("MISMATCH t=%0t read answer missing", $time);
            tally_and_finish();
        end
        `CHK(d, e)
    endtask

    task automatic wrx(input logic [15:0] a, input logic [15:0] d, input logic eRef);
        logic r;
        u_modbus_master_model.wr(a, d, r);
        `CHK(r, eRef)
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    initial
    begin
        int i;
        time t0;
        for (i = 0; i < 16; i++)
            statusValues[i*32 +: 32] = 32'hA000_0000 | i;
        statusValues[14*32 +: 32] = 32'd6000;
        waitc(5);
        sys_rst = 1'b0;
        rdx(`ADDR_FW_REV, FW_VALUE);
        rdx(`ADDR_FW_REV + 16'h0001, 16'h0000);
        rdx(`ADDR_ALARM_CODE, 16'h0000);
        rdx(`ADDR_STATUS_SEL, 16'h0001);
        rdx(`ADDR_ANALOG_SEL, 16'h0000);
        rdx(`ADDR_SLAVE_ADDR, 16'h007F);
        rdx(`ADDR_RESP_DELAY, 16'h0000);
        rdx(`ADDR_UV_THRESH, 16'h00A0);
        for (i = 0; i < 10; i++)
            rdx(`ADDR_HIST_NEWEST + i[15:0], 16'h0000);
        // Monitor select: nibble split, range and nibble limits
        wrx(`ADDR_ANALOG_SEL, 16'h0073, 1'b0);
        waitc(2);
        `CHK(analogCh1Sel, 3'd7)
        `CHK(analogCh2Sel, 3'd3)
        wrx(`ADDR_ANALOG_SEL, 16'h0078, 1'b1);
        wrx(`ADDR_ANALOG_SEL, 16'h0008, 1'b1);
        rdx(`ADDR_ANALOG_SEL, 16'h0073);
        // Read-only, odd and unmapped places refuse writes
        wrx(`ADDR_FW_REV, 16'h1234, 1'b1);
        wrx(`ADDR_ALARM_CODE, 16'h0001, 1'b1);
        wrx(`ADDR_HIST_SECOND, 16'h0001, 1'b1);
        wrx(16'h0005, 16'h0001, 1'b1);
        wrx(16'h0300, 16'h0001, 1'b1);
        rdx(`ADDR_FW_REV, FW_VALUE);
        // Status selector decoding, including the clamped index position
        wrx(`ADDR_STATUS_SEL, 16'h001B, 1'b1);
        wrx(`ADDR_STATUS_SEL, 16'h0003, 1'b0);
        waitc(3);
        `CHK(driveStatusValue, 32'hA000_0003)
        wrx(`ADDR_STATUS_SEL, 16'h000C, 1'b0);
        waitc(3);
        `CHK(driveStatusValue, 32'hA000_000C)
        wrx(`ADDR_STATUS_SEL, 16'h0012, 1'b0);
        waitc(3);
        `CHK(driveStatusValue, 32'd5000)
        statusValues[14*32 +: 32] = 32'hFFFF_E4A8;
        waitc(3);
        `CHK(driveStatusValue, 32'hFFFF_EC78)
        wrx(`ADDR_STATUS_SEL, 16'h0013, 1'b0);
        waitc(3);
        `CHK(driveStatusValue, 32'hA000_000C)
        wrx(`ADDR_STATUS_SEL, 16'h001A, 1'b0);
        // Servo on: monitor select locked, undervoltage raised and self-cleared
        servoOnPin = 1'b1;
        waitc(5);
        `CHK(driveStatusValue, 32'hA000_0003)
        wrx(`ADDR_ANALOG_SEL, 16'h0011, 1'b1);
        wrx(`ADDR_STATUS_SEL, 16'h0007, 1'b0);
        rdx(`ADDR_ANALOG_SEL, 16'h0073);
        mainVoltage = 16'd150;
        waitc(4);
        `CHK(undervoltageDetect, 1'b1)
        rdx(`ADDR_ALARM_CODE, 16'h0003);
        mainVoltage = 16'd220;
        waitc(4);
        rdx(`ADDR_ALARM_CODE, 16'h0000);
        servoOnPin = 1'b0;
        mainVoltage = 16'd150;
        waitc(6);
        rdx(`ADDR_ALARM_CODE, 16'h0000);
        wrx(`ADDR_UV_THRESH, 16'd100, 1'b0);
        waitc(3);
        `CHK(undervoltageDetect, 1'b0)
        mainVoltage = 16'd220;
        // Every fault source alone, then history order
        for (i = 0; i < 31; i++)
        begin
            faultVec = 31'd1 << i;
            waitc(4);
            rdx(`ADDR_ALARM_CODE, codes[i]);
            faultVec = 31'h0000_0000;
            waitc(4);
        end
        rdx(`ADDR_HIST_NEWEST, 16'h0380);
        rdx(`ADDR_HIST_NEWEST + 16'h0001, 16'h0000);
        rdx(`ADDR_HIST_SECOND, 16'h0285);
        rdx(`ADDR_HIST_THIRD, 16'h0283);
        rdx(`ADDR_HIST_FOURTH, 16'h0099);
        rdx(`ADDR_HIST_OLDEST, 16'h0040);
        faultVec = 31'h0000_4001;
        waitc(4);
        rdx(`ADDR_ALARM_CODE, 16'h0001);
        faultVec = 31'h0000_0000;
        // Slave address stored now, output stays at the default 127
        wrx(`ADDR_SLAVE_ADDR, 16'h0010, 1'b0);
        rdx(`ADDR_SLAVE_ADDR, 16'h0010);
        `CHK(slaveAddress, 8'd127)
        // One delay step stretches the answer by 50000 cycles
        wrx(`ADDR_RESP_DELAY, 16'h0001, 1'b0);
        t0 = $time;
        rdx(`ADDR_ANALOG_SEL, 16'h0073);
        `CHK(($time - t0) >= 500000 && ($time - t0) <= 500200, 1'b1)
        wrx(`ADDR_RESP_DELAY, 16'h0000, 1'b0);
        tally_and_finish();
    end
endmodule // drive_param_bank_tb_top
